// File: rtl/gsa_defines.vh
`ifndef GSA_DEFINES_VH
`define GSA_DEFINES_VH

// Register offsets
`define GSA_OFF_OP_MODE 16'h251C
`define GSA_OFF_TOTAL_COUNT 16'h2710
`define GSA_OFF_SEG_LEN 16'h271A
`define GSA_OFF_REPEAT 16'h2724
`define GSA_OFF_PRE_GATE 16'h272E
`define GSA_OFF_POST_GATE 16'h2774
`define GSA_OFF_CONTROL 16'h2800
`define GSA_OFF_COMMAND 16'h2804
`define GSA_OFF_STATUS 16'h2808

// Operating mode codes
`define GSA_MODE_STD_MULTI 32'h0000_0002
`define GSA_MODE_STD_GATE 32'h0000_0004
`define GSA_MODE_FIFO_MULTI 32'h0000_0020
`define GSA_MODE_FIFO_GATE 32'h0000_0040

// Control bits
`define GSA_CTL_GATE_INTERNAL 0
`define GSA_CTL_TS_ENABLE 1

// Command bits
`define GSA_CMD_START 0
`define GSA_CMD_STOP 1
`define GSA_CMD_SW_TRIG 2

// Status bits
`define GSA_ST_RUNNING 0
`define GSA_ST_PRE_ERR 1
`define GSA_ST_CFG_ERR 2

// Length limits, in samples per channel
`define GSA_LEN_STEP_MASK 64'h0000_0000_0000_001F
`define GSA_PRE_MIN 64'h0000_0000_0000_0020
`define GSA_PRE_MAX 64'h0000_0000_0000_1000
`define GSA_POST_MIN 64'h0000_0000_0000_0020
`define GSA_POST_MAX 64'h0000_0001_FFFF_FFE0
`define GSA_SEG_MIN 64'h0000_0000_0000_0040

// Reset values
`define GSA_RST_PRE 64'h0000_0000_0000_0020
`define GSA_RST_POST 64'h0000_0000_0000_0020
`define GSA_RST_SEG 64'h0000_0000_0000_0040
`define GSA_RST_TOTAL 64'h0000_0000_0000_0040

// Pre-window ring depth and sample width
`define GSA_RING_AW 12
`define GSA_DATA_W 32

`endif

// File: rtl/gsa_acquisition.v
`timescale 1ns/100ps
`include "gsa_defines.vh"

// How it works
// - Gate modes store only while gate holds, plus windows
// - Gate from pin or internal source, selectable
// - Keep pre-gate samples before each gate
// - Keep post-gate samples after gate end
// - Oversized gated pre length raises error, no arm
// - One timestamp per accepted trigger segment
// - Timestamp marks trigger, not segment start
// - Any trigger source, software included, starts segments
// - All lengths count samples per channel
// - Streamed segment is pre plus post
// - Zero repeat count means run until stopped in FIFO modes
module gsa_acquisition (
  clk,
  sys_rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  sample_valid,
  sample_data,
  gate_pin,
  gate_int,
  trig_pin,
  trig_int,
  store_valid,
  store_data,
  ts_valid,
  ts_value,
  running,
  pre_length_error
);
  input wire clk;
  input wire sys_rst;
  input wire [15:0] reg_addr;
  input wire [63:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [63:0] reg_rdata;
  input wire sample_valid;
  input wire [`GSA_DATA_W-1:0] sample_data;
  input wire gate_pin;
  input wire gate_int;
  input wire trig_pin;
  input wire trig_int;
  output reg store_valid;
  output reg [`GSA_DATA_W-1:0] store_data;
  output reg ts_valid;
  output reg [63:0] ts_value;
  output reg running;
  output reg pre_length_error;

  reg [31:0] op_mode_reg;
  reg [63:0] total_count_reg;
  reg [63:0] seg_len_reg;
  reg [31:0] repeat_reg;
  reg [63:0] pre_reg;
  reg [63:0] post_reg;
  reg [1:0] ctl_reg;
  reg cfg_err_reg;
  reg gate_s1_reg;
  reg gate_s2_reg;
  reg trig_s1_reg;
  reg trig_s2_reg;
  reg trig_prev_reg;
  reg trig_pend_reg;
  reg gate_prev_reg;
  reg gate_ok_reg;
  reg [63:0] keep_cnt_reg;
  reg [31:0] done_cnt_reg;
  reg [63:0] stored_cnt_reg;
  reg [63:0] ts_cnt_reg;
  reg [`GSA_RING_AW-1:0] wp_reg;
  reg [`GSA_DATA_W-1:0] ring [0:(1<<`GSA_RING_AW)-1];

  wire mode_gate = (op_mode_reg == `GSA_MODE_STD_GATE) ||
    (op_mode_reg == `GSA_MODE_FIFO_GATE);
  wire mode_multi = (op_mode_reg == `GSA_MODE_STD_MULTI) ||
    (op_mode_reg == `GSA_MODE_FIFO_MULTI);
  wire mode_std = (op_mode_reg == `GSA_MODE_STD_GATE) ||
    (op_mode_reg == `GSA_MODE_STD_MULTI);
  // Pre length follows from segment minus post in segmented modes
  wire [63:0] seg_pre = seg_len_reg - post_reg;
  wire [63:0] pre_eff = mode_multi ? seg_pre : pre_reg;
  wire pre_bad = (pre_reg < `GSA_PRE_MIN) || (pre_reg > `GSA_PRE_MAX) ||
    ((pre_reg & `GSA_LEN_STEP_MASK) != 64'h0);
  wire post_bad = (post_reg < `GSA_POST_MIN) ||
    (post_reg > `GSA_POST_MAX) ||
    ((post_reg & `GSA_LEN_STEP_MASK) != 64'h0);
  wire seg_bad = (seg_len_reg < `GSA_SEG_MIN) ||
    ((seg_len_reg & `GSA_LEN_STEP_MASK) != 64'h0) ||
    (seg_len_reg <= post_reg) || (seg_pre > `GSA_PRE_MAX);
  wire cfg_bad = post_bad || (mode_multi && seg_bad) ||
    !(mode_gate || mode_multi);

  wire cmd_wr = reg_wr && (reg_addr == `GSA_OFF_COMMAND);
  wire cmd_start = cmd_wr && reg_wdata[`GSA_CMD_START];
  wire cmd_stop = cmd_wr && reg_wdata[`GSA_CMD_STOP];
  wire sw_trig = cmd_wr && reg_wdata[`GSA_CMD_SW_TRIG];
  // A trigger between sample strobes waits for the next one
  wire trig_event = (trig_s2_reg && !trig_prev_reg) || trig_int ||
    sw_trig;

  wire gate_now = ctl_reg[`GSA_CTL_GATE_INTERNAL] ? gate_int :
    gate_s2_reg;
  wire gate_rise = gate_now && !gate_prev_reg;
  // Zero repeat never runs out; standard modes end on total only
  wire room = mode_std || (repeat_reg == 32'h0) ||
    (done_cnt_reg < repeat_reg);
  wire gate_eff = gate_now && (gate_ok_reg || (gate_rise && room));
  wire seg_take = trig_pend_reg && (keep_cnt_reg == 64'h0) && room;
  wire take = mode_gate ? gate_eff : seg_take;
  wire keep_now = take || (keep_cnt_reg != 64'h0);
  wire [63:0] keep_load = mode_gate ? (pre_reg + post_reg) :
    (seg_len_reg - 64'h1);
  wire fifo_done = !mode_std && (repeat_reg != 32'h0) &&
    !room && !keep_now;
  wire std_done = mode_std && keep_now &&
    (stored_cnt_reg + 64'h1 >= total_count_reg);
  // Output lags input by the pre length, so the window before a
  // gate or trigger is still in the ring when the decision is made
  wire [`GSA_RING_AW-1:0] rd_addr = wp_reg - pre_eff[`GSA_RING_AW-1:0];

  always @(posedge clk)
    if (sample_valid)
      ring[wp_reg] <= sample_data;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end
    else
    begin
      gate_s1_reg <= gate_pin;
      gate_s2_reg <= gate_s1_reg;
      trig_s1_reg <= trig_pin;
      trig_s2_reg <= trig_s1_reg;
      trig_prev_reg <= trig_s2_reg;
    end
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_mode_reg <= `GSA_MODE_FIFO_GATE;
      total_count_reg <= `GSA_RST_TOTAL;
      seg_len_reg <= `GSA_RST_SEG;
      repeat_reg <= 32'h0;
      pre_reg <= `GSA_RST_PRE;
      post_reg <= `GSA_RST_POST;
      ctl_reg <= 2'h0;
      reg_rdata <= 64'h0;
    end
    else
    begin
      if (reg_wr && !running)
      begin
        case (reg_addr)
          `GSA_OFF_OP_MODE: op_mode_reg <= reg_wdata[31:0];
          `GSA_OFF_TOTAL_COUNT: total_count_reg <= reg_wdata;
          `GSA_OFF_SEG_LEN: seg_len_reg <= reg_wdata;
          `GSA_OFF_REPEAT: repeat_reg <= reg_wdata[31:0];
          `GSA_OFF_PRE_GATE: pre_reg <= reg_wdata;
          `GSA_OFF_POST_GATE: post_reg <= reg_wdata;
          `GSA_OFF_CONTROL: ctl_reg <= reg_wdata[1:0];
          default: ;
        endcase
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `GSA_OFF_OP_MODE: reg_rdata <= {32'h0, op_mode_reg};
          `GSA_OFF_TOTAL_COUNT: reg_rdata <= total_count_reg;
          `GSA_OFF_SEG_LEN: reg_rdata <= seg_len_reg;
          `GSA_OFF_REPEAT: reg_rdata <= {32'h0, repeat_reg};
          `GSA_OFF_PRE_GATE: reg_rdata <= pre_reg;
          `GSA_OFF_POST_GATE: reg_rdata <= post_reg;
          `GSA_OFF_CONTROL: reg_rdata <= {62'h0, ctl_reg};
          `GSA_OFF_STATUS: reg_rdata <= {61'h0, cfg_err_reg,
            pre_length_error, running};
          default: reg_rdata <= 64'h0;
        endcase
      end
    end
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      running <= 1'b0;
      pre_length_error <= 1'b0;
      cfg_err_reg <= 1'b0;
      trig_pend_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
      gate_ok_reg <= 1'b0;
      keep_cnt_reg <= 64'h0;
      done_cnt_reg <= 32'h0;
      stored_cnt_reg <= 64'h0;
      ts_cnt_reg <= 64'h0;
      wp_reg <= {`GSA_RING_AW{1'b0}};
      store_valid <= 1'b0;
      store_data <= {`GSA_DATA_W{1'b0}};
      ts_valid <= 1'b0;
      ts_value <= 64'h0;
    end
    else
    begin
      store_valid <= 1'b0;
      ts_valid <= 1'b0;
      if (cmd_start && !running)
      begin
        // Arming is refused rather than clipping a bad length
        if (mode_gate && pre_bad)
        begin
          pre_length_error <= 1'b1;
        end
        else if (cfg_bad)
        begin
          cfg_err_reg <= 1'b1;
        end
        else
        begin
          running <= 1'b1;
          pre_length_error <= 1'b0;
          cfg_err_reg <= 1'b0;
          keep_cnt_reg <= 64'h0;
          done_cnt_reg <= 32'h0;
          stored_cnt_reg <= 64'h0;
          gate_ok_reg <= 1'b0;
        end
      end
      else if (cmd_stop)
      begin
        running <= 1'b0;
      end
      if (sample_valid)
      begin
        wp_reg <= wp_reg + {{(`GSA_RING_AW-1){1'b0}}, 1'b1};
        ts_cnt_reg <= ts_cnt_reg + 64'h1;
        gate_prev_reg <= gate_now;
        store_data <= ring[rd_addr];
        trig_pend_reg <= trig_event;
        if (running)
        begin
          store_valid <= keep_now;
          if (keep_now)
            stored_cnt_reg <= stored_cnt_reg + 64'h1;
          if (take)
          begin
            keep_cnt_reg <= keep_load;
          end
          else if (keep_cnt_reg != 64'h0)
          begin
            keep_cnt_reg <= keep_cnt_reg - 64'h1;
          end
          if (!gate_now)
          begin
            gate_ok_reg <= 1'b0;
          end
          else if (gate_rise && room)
          begin
            gate_ok_reg <= 1'b1;
          end
          if ((mode_gate && gate_rise && room) || (mode_multi && seg_take))
          begin
            done_cnt_reg <= done_cnt_reg + 32'h1;
          end
          if (mode_multi && seg_take && ctl_reg[`GSA_CTL_TS_ENABLE])
          begin
            ts_valid <= 1'b1;
            ts_value <= ts_cnt_reg;
          end
          if (fifo_done || std_done)
          begin
            running <= 1'b0;
          end
        end
      end
      else if (trig_event)
      begin
        trig_pend_reg <= 1'b1;
      end
    end
  end
endmodule

// File: tb/gsa_acquisition_sva.sv
`timescale 1ns/100ps
`include "gsa_defines.vh"
module gsa_chk (
  input wire clk,
  input wire sys_rst,
  input wire [15:0] reg_addr,
  input wire [63:0] reg_wdata,
  input wire reg_wr,
  input wire sample_valid,
  input wire store_valid,
  input wire ts_valid,
  input wire running,
  input wire pre_length_error
);
  reg pre_big_reg;
  reg gate_mode_reg;
  wire cmd = reg_wr && reg_addr == `GSA_OFF_COMMAND;
  wire start = cmd && !running && reg_wdata[0] && !reg_wdata[1];
  wire cfg = reg_wr && !running;
  // Writes while running are dropped, so the shadow skips them too
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      pre_big_reg <= 1'b0;
      gate_mode_reg <= 1'b1;
    end
    else if (cfg && reg_addr == `GSA_OFF_PRE_GATE)
      pre_big_reg <= reg_wdata > `GSA_PRE_MAX;
    else if (cfg && reg_addr == `GSA_OFF_OP_MODE)
      gate_mode_reg <= reg_wdata[2] | reg_wdata[6];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_STORE_STROBE: assert property (store_valid |-> $past(sample_valid))
    else $error("store without strobe");
  AST_STORE_RUN: assert property (store_valid |-> $past(running))
    else $error("store while idle");
  AST_TS_STROBE: assert property (ts_valid |-> $past(sample_valid))
    else $error("stamp without strobe");
  AST_TS_FIRST: assert property (ts_valid |-> store_valid)
    else $error("stamp off first sample");
  AST_TS_ONCE: assert property (ts_valid |=> !ts_valid [*8])
    else $error("second stamp in segment");
  AST_ERR_IDLE: assert property ($rose(pre_length_error) |-> !running)
    else $error("error while armed");
  AST_PRE_REJECT: assert property (start && pre_big_reg && gate_mode_reg
    |=> pre_length_error && !running) else $error("long pre accepted");
  AST_STOP: assert property (cmd && reg_wdata[1] |=> !running)
    else $error("stop ignored");
  cover property (ts_valid);
  cover property ($rose(pre_length_error));
  cover property ($fell(running));
endmodule
bind gsa_acquisition gsa_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .sample_valid, .store_valid, .ts_valid, .running,
  .pre_length_error);

// File: tb/gsa_src_model.sv
`timescale 1ns/100ps
module gsa_src_model (
  input wire clk,
  output reg gate_pin = 1'b0,
  output reg trig_pin = 1'b0
);
  task gate(input integer n);
  begin
    @(negedge clk);
    gate_pin = 1'b1;
    repeat (n) @(negedge clk);
    gate_pin = 1'b0;
  end
  endtask
  // Held 3 cycles so the 2-stage sync sees one clean edge
  task trig;
  begin
    @(negedge clk);
    trig_pin = 1'b1;
    repeat (3) @(negedge clk);
    trig_pin = 1'b0;
  end
  endtask
endmodule

// File: tb/gsa_acquisition_bench.sv
`timescale 1ns/100ps
`include "gsa_defines.vh"
module gsa_acquisition_bench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg sample_valid = 1'b0;
  reg gate_int = 1'b0;
  reg trig_int = 1'b0;
  reg stream = 1'b0;
  reg [15:0] reg_addr = 16'h0;
  reg [63:0] reg_wdata = 64'h0;
  reg [31:0] sample_data = 32'h0;
  reg [63:0] rd_val, diff_a, diff_b;
  wire [63:0] reg_rdata, ts_value;
  wire [31:0] store_data;
  wire store_valid, ts_valid, running, pre_length_error, gate_pin, trig_pin;
  integer n_fail = 0;
  integer total_checks = 0;
  integer n_store = 0;
  integer n_ts = 0;
  gsa_acquisition DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sample_valid, .sample_data, .gate_pin, .gate_int,
    .trig_pin, .trig_int, .store_valid, .store_data, .ts_valid, .ts_value,
    .running, .pre_length_error);
  gsa_src_model SRC (.clk, .gate_pin, .trig_pin);
  initial
    forever #10 clk = ~clk;
  // A strobe every cycle with a running count, so a word tells its age
  always @(negedge clk)
  begin
    sample_valid <= stream;
    sample_data <= sample_data + {31'h0, stream};
  end
  always @(negedge clk)
  begin
    if (store_valid === 1'b1)
      n_store = n_store + 1;
    if (ts_valid === 1'b1)
    begin
      n_ts = n_ts + 1;
      diff_a = diff_b;
      // A word holds its strobe index plus one
      diff_b = ts_value + 64'h1 - {32'h0, store_data};
    end
  end
  task finish_test;
  begin
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [15:0] a, input [63:0] d);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [15:0] a);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  end
  endtask
  task wait_idle;
    integer i;
  begin
    for (i = 0; i < 3000 && running !== 1'b0; i = i + 1)
      @(negedge clk);
    if (running !== 1'b0)
    begin
      chk(64'(running), 64'h0);
      finish_test;
    end
  end
  endtask
  task gint(input integer n);
  begin
    @(negedge clk);
    gate_int = 1'b1;
    repeat (n) @(negedge clk);
    gate_int = 1'b0;
  end
  endtask
  task t_reset;
  begin
    rd(`GSA_OFF_PRE_GATE);
    chk(rd_val, 64'h20);
    rd(`GSA_OFF_POST_GATE);
    chk(rd_val, 64'h20);
    $display("t_reset done");
  end
  endtask
  // The unselected source pulses first and must store nothing
  task t_gate(input [63:0] ctl);
  begin
    wr(`GSA_OFF_CONTROL, ctl);
    wr(`GSA_OFF_REPEAT, 64'h1);
    wr(`GSA_OFF_COMMAND, 64'h1);
    n_store = 0;
    if (ctl[0])
      SRC.gate(10);
    else
      gint(10);
    repeat (100) @(negedge clk);
    chk(64'(n_store), 64'h0);
    if (ctl[0])
      gint(20);
    else
      SRC.gate(20);
    wait_idle;
    chk(64'(n_store), 64'h54);
    $display("t_gate done");
  end
  endtask
  task t_pre_err;
  begin
    wr(`GSA_OFF_PRE_GATE, 64'h1020);
    wr(`GSA_OFF_COMMAND, 64'h1);
    chk({63'h0, running}, 64'h0);
    rd(`GSA_OFF_STATUS);
    chk(rd_val & 64'h2, 64'h2);
    wr(`GSA_OFF_PRE_GATE, 64'h30);
    wr(`GSA_OFF_COMMAND, 64'h1);
    chk({63'h0, running}, 64'h0);
    wr(`GSA_OFF_PRE_GATE, 64'h1000);
    wr(`GSA_OFF_COMMAND, 64'h1);
    chk({62'h0, running, pre_length_error}, 64'h2);
    wr(`GSA_OFF_COMMAND, 64'h2);
    chk({63'h0, running}, 64'h0);
    wr(`GSA_OFF_PRE_GATE, 64'h20);
    wr(`GSA_OFF_POST_GATE, 64'h30);
    wr(`GSA_OFF_COMMAND, 64'h1);
    rd(`GSA_OFF_STATUS);
    chk(rd_val, 64'h4);
    wr(`GSA_OFF_POST_GATE, 64'h20);
    $display("t_pre_err done");
  end
  endtask
  // Two gates in standard mode, the second cut by the total count
  task t_std;
  begin
    wr(`GSA_OFF_OP_MODE, `GSA_MODE_STD_GATE);
    wr(`GSA_OFF_TOTAL_COUNT, 64'h80);
    wr(`GSA_OFF_COMMAND, 64'h1);
    n_store = 0;
    gint(20);
    repeat (40) @(negedge clk);
    gint(100);
    wait_idle;
    chk(64'(n_store), 64'h80);
    $display("t_std done");
  end
  endtask
  // Three sources fire, the fourth trigger arrives after the count ran out
  task t_seg;
  begin
    wr(`GSA_OFF_OP_MODE, `GSA_MODE_FIFO_MULTI);
    wr(`GSA_OFF_SEG_LEN, 64'h40);
    wr(`GSA_OFF_REPEAT, 64'h3);
    wr(`GSA_OFF_CONTROL, 64'h2);
    wr(`GSA_OFF_COMMAND, 64'h1);
    n_store = 0;
    n_ts = 0;
    repeat (60) @(negedge clk);
    wr(`GSA_OFF_COMMAND, 64'h4);
    repeat (100) @(negedge clk);
    SRC.trig;
    repeat (100) @(negedge clk);
    trig_int = 1'b1;
    @(negedge clk);
    trig_int = 1'b0;
    wait_idle;
    trig_int = 1'b1;
    @(negedge clk);
    trig_int = 1'b0;
    repeat (80) @(negedge clk);
    chk(64'(n_store), 64'hC0);
    chk(64'(n_ts), 64'h3);
    chk(diff_a, diff_b);
    chk(diff_b, 64'h20);
    $display("t_seg done");
  end
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    stream = 1'b1;
    t_reset;
    t_gate(64'h0);
    t_gate(64'h1);
    t_pre_err;
    t_std;
    t_seg;
    finish_test;
  end
endmodule
